// ==== bench/converter_model.sv ====
// Behavioural converter that answers each finished sampling phase with a done pulse.
`timescale 1ns/1ps
module converter_model (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // Sequencer side
  input  wire logic sampling_i,
  input  wire logic slow_i,
  // Converter answer
  output logic      done_o
);
  logic       was_sampling;
  logic [2:0] wait_count;
  // The answer follows only the end of sampling, so a stale done lands in sampling, where it is ignored.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      was_sampling <= 1'b0;
      wait_count   <= 3'h0;
      done_o       <= 1'b0;
    end else begin
      was_sampling <= sampling_i;
      done_o       <= 1'b0;
      if (was_sampling && !sampling_i) begin
        wait_count <= slow_i ? 3'h6 : 3'h1;
      end else if (wait_count == 3'h1) begin
        done_o     <= 1'b1;
        wait_count <= 3'h0;
      end else if (wait_count != 3'h0) begin
        wait_count <= wait_count - 3'h1;
      end
    end
  end
endmodule : converter_model

// ==== bench/tb_top.sv ====
// Self-checking bench for the conversion start and channel select block.
`timescale 1ns/1ps
module tb_top;
  import adc_start_pkg::*;
  logic        clock_i = 0, sys_rst_i = 1, reg_write_i = 0, reg_read_i = 0;
  logic        trigger_pin_i = 0, result_overrun_i = 0, slow = 0, rd_pend = 0;
  logic [2:0]  reg_addr_i = 0;
  logic [7:0]  reg_wdata_i = 0, reg_rdata_o, c;
  logic [3:0]  source_select_o, len, wrap;
  logic        conversion_done_i, sample_start_o, sampling_o, busy_o, special_select_o, reserved_source_o;
  logic [31:0] r;
  logic [7:0]  rd_q[$], src_q[$];
  int          num_errors = 0, n_tests = 0, starts = 0, seed = 6761, n0;

  adc_sequence_start_channel_select dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .trigger_pin_i(trigger_pin_i), .conversion_done_i(conversion_done_i), .result_overrun_i(result_overrun_i),
    .sample_start_o(sample_start_o), .sampling_o(sampling_o), .busy_o(busy_o),
    .special_select_o(special_select_o), .source_select_o(source_select_o),
    .reserved_source_o(reserved_source_o));
  converter_model conv_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sampling_i(sampling_o), .slow_i(slow),
    .done_o(conversion_done_i));

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task results;
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1;
    @(posedge clock_i);
    reg_write_i <= 0;
  endtask : wr

  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1;
    rd_q.push_back(e);
    @(posedge clock_i);
    reg_read_i <= 0;
  endtask : rd

  // Start control write followed at once by its read back.
  task wrd(input logic [7:0] d, input logic [7:0] e);
    @(posedge clock_i);
    reg_addr_i  <= 3'h5;
    reg_wdata_i <= d;
    reg_write_i <= 1;
    @(posedge clock_i);
    reg_write_i <= 0;
    reg_read_i  <= 1;
    rd_q.push_back(e);
    @(posedge clock_i);
    reg_read_i <= 0;
  endtask : wrd

  // Notes the expected sources of one sequence; sampling must be high with each start.
  task seq(input logic [7:0] cv);
    logic [2:0] ch;
    logic [3:0] w;
    logic       fw;
    int         n;
    ch = cv[3] ? 3'h7 : cv[2:0];
    w  = wrap[3] ? 4'h7 : wrap;
    fw = {1'b0, ch} > w;
    n  = (len == 4'h0 || len[3]) ? 8 : int'(len);
    for (int k = 0; k < n; k++) begin
      if (cv[6]) src_q.push_back({2'b10, !(cv[3:0] inside {4'h1, 4'h4, 4'h5, 4'h6}), 1'b1, cv[3:0]});
      else src_q.push_back({5'h10, ch});
      if (cv[4] && !cv[6]) begin
        if (ch == (fw ? 3'h7 : w[2:0])) begin
          ch = 3'h0;
          fw = 1'b0;
        end else ch = ch + 3'h1;
      end
    end
  endtask : seq

  task idle;
    repeat (3) @(posedge clock_i);
    for (int t = 0; t < 3000 && busy_o !== 1'b0; t++) @(posedge clock_i);
    chk({7'h0, busy_o}, 8'h00);
  endtask : idle

  task pin;
    @(posedge clock_i);
    trigger_pin_i <= 1;
    repeat (4) @(posedge clock_i);
    trigger_pin_i <= 0;
    repeat (4) @(posedge clock_i);
  endtask : pin

  always @(posedge clock_i) begin
    if (rd_pend) chk(reg_rdata_o, rd_q.pop_front());
    rd_pend <= reg_read_i;
    if (sample_start_o === 1'b1) begin
      starts <= starts + 1;
      chk({sampling_o, 1'b0, reserved_source_o, special_select_o, source_select_o},
          src_q.size() ? src_q.pop_front() : 8'hFF);
    end
  end

  initial begin
    #150000;
    num_errors++;
    results;
  end

  initial begin
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 0;
    rd(3'h5, 8'h00);
    rd(3'h7, 8'h00);
    // Every length code, random codes and wrap points; the first pass forces a wrap at seven.
    for (int i = 0; i < 16; i++) begin
      r    = $random(seed);
      len  = i[3:0];
      wrap = i == 0 ? 4'h2 : r[3:0];
      c    = i == 0 ? 8'h16 : r[15:8] & 8'h5F;
      slow <= r[16];
      wr(3'h0, {4'h0, wrap});
      wr(3'h3, {4'h0, len});
      seq(c);
      wrd(c | 8'h80, c);
      idle;
    end
    len = 4'h2;
    wr(3'h3, 8'h12);
    repeat (4) src_q.push_back(8'h84);
    n0 = starts;
    wr(3'h5, 8'h24);
    for (int t = 0; t < 2000 && starts < n0 + 4; t++) @(posedge clock_i);
    chk(8'(starts - n0), 8'h04);
    @(posedge clock_i);
    result_overrun_i <= 1;
    @(posedge clock_i);
    result_overrun_i <= 0;
    rd(3'h6, 8'h91);
    seq(8'h01);
    wr(3'h5, 8'h01);
    rd(3'h6, 8'h00);
    idle;
    len = 4'h1;
    wr(3'h3, 8'h21);
    pin;
    wr(3'h5, 8'h23);
    repeat (80) @(posedge clock_i);
    seq(8'h23);
    pin;
    pin;
    idle;
    repeat (100) @(posedge clock_i);
    rd(3'h6, 8'hA0);
    seq(8'h23);
    pin;
    idle;
    repeat (60) @(posedge clock_i);
    chk(8'(src_q.size()), 8'h00);
    results;
  end
endmodule : tb_top

// ==== hdl/adc_sequence_start_channel_select.sv ====
// Conversion start and channel selection control for the analog-to-digital unit sequencer.
// Behaviour
// - Start control write aborts, and starts sequence unless external trigger is on.
// - External trigger needs one arming write first.
// - Conversion start is first sampling cycle.
// - Bit 6 enables special source selection.
// - Bit 5 picks single or continuous sequences.
// - External trigger runs exactly one sequence.
// - Single channel mode repeats the coded input.
// - Multi channel converts length channels from code.
// - Next channel increments, wrapping after wrap channel.
// - Start above wrap first wraps at seven.
// - Codes eight to fifteen select input seven.
// - Special codes pick source, reference or midpoint.
// - Length zero or top bit gives eight.
// - Start write clears the three status flags.
// - Abort or start clears the conversion counter.
`timescale 1ns/1ps
module adc_sequence_start_channel_select (
  // Clock and reset
  input  wire logic                                clock_i,
  input  wire logic                                sys_rst_i,
  // Register port
  input  wire logic [adc_start_pkg::ADDR_WIDTH-1:0] reg_addr_i,
  input  wire logic [adc_start_pkg::DATA_WIDTH-1:0] reg_wdata_i,
  input  wire logic                                reg_write_i,
  input  wire logic                                reg_read_i,
  output logic      [adc_start_pkg::DATA_WIDTH-1:0] reg_rdata_o,
  // External trigger and converter feedback
  input  wire logic                                trigger_pin_i,
  input  wire logic                                conversion_done_i,
  input  wire logic                                result_overrun_i,
  // Multiplexer and sequencer control
  output logic                                     sample_start_o,
  output logic                                     sampling_o,
  output logic                                     busy_o,
  output logic                                     special_select_o,
  output logic      [3:0]                          source_select_o,
  output logic                                     reserved_source_o
);

  import adc_start_pkg::*;

  logic [7:0]          start_control;
  logic [7:0]          sequence_config;
  logic [3:0]          wrap_channel_field;
  logic                sequence_complete_flag;
  logic                trigger_overrun_flag;
  logic                result_overrun_flag;
  logic [3:0]          conversion_counter;
  logic [3:0]          conversion_index;
  logic [2:0]          sample_count;
  logic [2:0]          current_channel;
  logic                first_wrap_pending;
  logic                armed;
  sequencer_state_type state;
  sequencer_state_type next_state;
  logic [2:0]          prev_channel;
  logic                wrap_now_q;

  logic                tick;
  logic                trigger_rise;
  logic                write_start;
  logic                write_config;
  logic                write_wrap;
  logic                write_status;
  logic                abort;
  logic [7:0]          effective_control;
  logic                external_trigger_enable;
  logic                continuous_run;
  logic                start_by_write;
  logic                trigger_start;
  logic                trigger_overrun_event;
  logic                conversion_end;
  logic                last_conversion;
  logic                sequence_end;
  logic                enter_sampling;
  logic                new_sequence;
  logic [2:0]          start_channel;
  logic [2:0]          next_channel;
  logic                wrap_now;

  converter_tick_divider u_divider (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (enter_sampling),
    .tick_o    (tick)
  );

  trigger_input_sync u_trigger_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (trigger_pin_i),
    .rise_o    (trigger_rise)
  );

  // Register decode.
  always_comb begin
    write_start  = 1'b0;
    write_config = 1'b0;
    write_wrap   = 1'b0;
    write_status = 1'b0;
    if (reg_addr_i == START_CONTROL_OFFSET) begin
      write_start = reg_write_i;
    end else if (reg_addr_i == SEQUENCE_CONFIG_OFFSET) begin
      write_config = reg_write_i;
    end else if (reg_addr_i == WRAP_CONTROL_OFFSET) begin
      write_wrap = reg_write_i;
    end else if (reg_addr_i == STATUS_OFFSET) begin
      write_status = reg_write_i;
    end
  end

  // A write takes effect in its own cycle, so the new sequence uses the fresh field values.
  assign effective_control       = write_start ? (reg_wdata_i & START_WRITE_MASK) : start_control;
  assign external_trigger_enable = sequence_config[EXT_TRIGGER_BIT];
  assign continuous_run          = start_control[CONTINUOUS_BIT] && !external_trigger_enable;
  assign abort                   = write_start || write_config || write_wrap;
  assign start_by_write          = write_start && !external_trigger_enable;
  assign trigger_start           = trigger_rise && external_trigger_enable && armed && state == IDLE && !abort;
  assign trigger_overrun_event   = trigger_rise && external_trigger_enable && armed && (state != IDLE);
  assign conversion_end          = (state == CONVERTING) && conversion_done_i;
  assign last_conversion         = (conversion_index + 4'h1) == decode_length(sequence_config[LENGTH_MSB:0]);
  assign sequence_end            = conversion_end && last_conversion && !abort;
  assign new_sequence            = start_by_write || (!abort && (trigger_start || (sequence_end && continuous_run)));
  assign enter_sampling          = new_sequence || (!abort && conversion_end && !last_conversion);
  assign start_channel           = analog_of_code(effective_control[CODE_MSB:0]);

  // Channel stepping in multi-channel mode.
  assign wrap_now = (current_channel == LAST_ANALOG) ||
                    (!first_wrap_pending && !wrap_channel_field[3] &&
                     current_channel == wrap_channel_field[2:0]);

  always_comb begin
    next_channel = current_channel;
    if (new_sequence) begin
      next_channel = start_channel;
    end else if (effective_control[MULTI_CHANNEL_BIT] && !effective_control[SPECIAL_ENABLE_BIT]) begin
      next_channel = wrap_now ? 3'h0 : current_channel + 3'h1;
    end
  end

  // Sequencer state.
  always_comb begin
    next_state = state;
    if (abort) begin
      next_state = start_by_write ? SAMPLING : IDLE;
    end else begin
      case (state)
        IDLE: begin
          if (trigger_start) begin
            next_state = SAMPLING;
          end
        end
        SAMPLING: begin
          if (tick && sample_count == SAMPLE_TICKS - 3'h1) begin
            next_state = CONVERTING;
          end
        end
        CONVERTING: begin
          if (conversion_done_i) begin
            next_state = enter_sampling ? SAMPLING : IDLE;
          end
        end
        default: begin
          next_state = IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state      <= IDLE;
      sampling_o <= 1'b0;
      busy_o     <= 1'b0;
    end else begin
      state      <= next_state;
      sampling_o <= next_state == SAMPLING;
      busy_o     <= next_state != IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || enter_sampling) begin
      sample_count <= 3'h0;
    end else if (state == SAMPLING && tick) begin
      sample_count <= sample_count + 3'h1;
    end
  end

  // Channel tracking and multiplexer outputs.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      current_channel    <= 3'h0;
      first_wrap_pending <= 1'b0;
    end else if (enter_sampling) begin
      current_channel <= next_channel;
      if (new_sequence) begin
        first_wrap_pending <= {1'b0, start_channel} > wrap_channel_field;
      end else if (next_channel == 3'h0) begin
        first_wrap_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sample_start_o    <= 1'b0;
      special_select_o  <= 1'b0;
      source_select_o   <= 4'h0;
      reserved_source_o <= 1'b0;
    end else begin
      sample_start_o <= enter_sampling;
      if (enter_sampling) begin
        special_select_o <= effective_control[SPECIAL_ENABLE_BIT];
        if (effective_control[SPECIAL_ENABLE_BIT]) begin
          source_select_o   <= effective_control[CODE_MSB:0];
          reserved_source_o <= !special_code_valid(effective_control[CODE_MSB:0]);
        end else begin
          source_select_o   <= {1'b0, next_channel};
          reserved_source_o <= 1'b0;
        end
      end
    end
  end

  // Counters within the sequence.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || abort || new_sequence) begin
      conversion_index <= 4'h0;
    end else if (conversion_end) begin
      conversion_index <= conversion_index + 4'h1;
    end
  end

  // FIFO mode keeps the counter after a sequence ends, but an abort or any new sequence start clears it.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || abort || new_sequence) begin
      conversion_counter <= 4'h0;
    end else if (sequence_end && !sequence_config[FIFO_MODE_BIT]) begin
      conversion_counter <= 4'h0;
    end else if (conversion_end) begin
      conversion_counter <= conversion_counter + 4'h1;
    end
  end

  // Software registers.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      start_control      <= START_RESET;
      sequence_config    <= CONFIG_RESET;
      wrap_channel_field <= WRAP_RESET;
    end else begin
      if (write_start) begin
        start_control <= reg_wdata_i & START_WRITE_MASK;
      end
      if (write_config) begin
        sequence_config <= reg_wdata_i & CONFIG_MASK;
      end
      if (write_wrap) begin
        wrap_channel_field <= reg_wdata_i[WRAP_MSB:0];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || write_config || write_wrap) begin
      armed <= 1'b0;
    end else if (write_start) begin
      armed <= 1'b1;
    end
  end

  // Status flags; a hardware set in the clearing cycle wins.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sequence_complete_flag <= 1'b0;
      trigger_overrun_flag   <= 1'b0;
      result_overrun_flag    <= 1'b0;
    end else begin
      if (sequence_end) begin
        sequence_complete_flag <= 1'b1;
      end else if (write_start || (write_status && reg_wdata_i[SEQ_COMPLETE_BIT])) begin
        sequence_complete_flag <= 1'b0;
      end
      if (trigger_overrun_event) begin
        trigger_overrun_flag <= 1'b1;
      end else if (abort || (write_status && reg_wdata_i[TRIGGER_OVERRUN_BIT])) begin
        trigger_overrun_flag <= 1'b0;
      end
      if (result_overrun_i) begin
        result_overrun_flag <= 1'b1;
      end else if (abort || (write_status && reg_wdata_i[RESULT_OVERRUN_BIT])) begin
        result_overrun_flag <= 1'b0;
      end
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !reg_read_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == START_CONTROL_OFFSET) begin
      reg_rdata_o <= start_control;
    end else if (reg_addr_i == SEQUENCE_CONFIG_OFFSET) begin
      reg_rdata_o <= sequence_config;
    end else if (reg_addr_i == WRAP_CONTROL_OFFSET) begin
      reg_rdata_o <= {4'h0, wrap_channel_field};
    end else if (reg_addr_i == STATUS_OFFSET) begin
      reg_rdata_o <= {sequence_complete_flag, 1'b0, trigger_overrun_flag, result_overrun_flag, conversion_counter};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Checks.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence start_write_seq;
    reg_write_i && reg_addr_i == START_CONTROL_OFFSET;
  endsequence
  sequence start_readback_seq;
    start_write_seq ##1 (reg_read_i && reg_addr_i == START_CONTROL_OFFSET && !reg_write_i);
  endsequence

  a_write_starts_run: assert property (start_write_seq and !external_trigger_enable |=>
    sample_start_o && sampling_o) else $error("Start write did not begin a sequence.");

  a_armed_trigger_run: assert property (trigger_rise && external_trigger_enable && !armed && !reg_write_i |=>
    !sample_start_o) else $error("Unarmed trigger started a sequence.");

  a_sample_first_cycle: assert property (sample_start_o |-> sampling_o && busy_o && sample_count == 3'h0)
    else $error("Conversion start is not a sampling cycle.");

  a_special_source: assert property (sample_start_o && special_select_o |->
    source_select_o == start_control[CODE_MSB:0]) else $error("Special source code mismatch.");

  a_single_run_stops: assert property (sequence_end && !continuous_run |=> !busy_o ##1 !sample_start_o)
    else $error("Single sequence did not stop.");

  a_trigger_one_run: assert property (sequence_end && external_trigger_enable |=> state == IDLE)
    else $error("External trigger ran more than one sequence.");

  a_single_channel: assert property (sample_start_o && !special_select_o &&
    !start_control[MULTI_CHANNEL_BIT] |-> source_select_o == {1'b0, analog_of_code(start_control[CODE_MSB:0])})
    else $error("Single channel mismatch.");

  a_multi_step: assert property (enter_sampling && !new_sequence && start_control[MULTI_CHANNEL_BIT] &&
    !start_control[SPECIAL_ENABLE_BIT] |=> source_select_o == (wrap_now_q ? 4'h0 : {1'b0, prev_channel + 3'h1}))
    else $error("Multi channel step is wrong.");

  a_length_count: assert property (new_sequence |=> conversion_index == 4'h0)
    else $error("Sequence length count not restarted.");

  a_start_clears_flags: assert property (start_write_seq and !result_overrun_i |=>
    !sequence_complete_flag && !trigger_overrun_flag && !result_overrun_flag) else $error("Flags not cleared.");

  a_counter_cleared: assert property (abort |=> conversion_counter == 4'h0)
    else $error("Conversion counter not cleared.");

  a_start_readback: assert property (start_readback_seq |=>
    reg_rdata_o == ($past(reg_wdata_i, 2) & START_WRITE_MASK)) else $error("Start control read back mismatch.");

  always_ff @(posedge clock_i) begin
    prev_channel <= current_channel;
    wrap_now_q   <= wrap_now;
  end

endmodule : adc_sequence_start_channel_select

// ==== hdl/adc_start_pkg.sv ====
// Constants, types and decode functions shared by the conversion start and channel select logic.
package adc_start_pkg;

  // Register port geometry and offsets.
  localparam int unsigned ADDR_WIDTH = 3;
  localparam int unsigned DATA_WIDTH = 8;
  localparam logic [ADDR_WIDTH-1:0] WRAP_CONTROL_OFFSET    = 3'h0;
  localparam logic [ADDR_WIDTH-1:0] SEQUENCE_CONFIG_OFFSET = 3'h3;
  localparam logic [ADDR_WIDTH-1:0] START_CONTROL_OFFSET   = 3'h5;
  localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET          = 3'h6;

  // Start control field layout.
  localparam int unsigned SPECIAL_ENABLE_BIT = 6;
  localparam int unsigned CONTINUOUS_BIT     = 5;
  localparam int unsigned MULTI_CHANNEL_BIT  = 4;
  localparam int unsigned CODE_MSB           = 3;
  localparam logic [7:0]  START_WRITE_MASK   = 8'h7F;
  localparam logic [7:0]  START_RESET        = 8'h00;

  // Sequence configuration field layout.
  localparam int unsigned EXT_TRIGGER_BIT = 5;
  localparam int unsigned FIFO_MODE_BIT   = 4;
  localparam int unsigned LENGTH_MSB      = 3;
  localparam logic [7:0]  CONFIG_MASK     = 8'h3F;
  localparam logic [7:0]  CONFIG_RESET    = 8'h00;

  // Wrap channel field.
  localparam int unsigned WRAP_MSB   = 3;
  localparam logic [3:0]  WRAP_RESET = 4'hF;

  // Status field layout.
  localparam int unsigned SEQ_COMPLETE_BIT    = 7;
  localparam int unsigned TRIGGER_OVERRUN_BIT = 5;
  localparam int unsigned RESULT_OVERRUN_BIT  = 4;

  // Converter clock and sampling phase.
  localparam int unsigned CONVERTER_DIVIDE = 12;
  localparam int unsigned DIVIDER_WIDTH    = 4;
  localparam logic [2:0]  SAMPLE_TICKS     = 3'h4;

  // Channel and length limits.
  localparam logic [2:0] LAST_ANALOG     = 3'h7;
  localparam logic [3:0] MAX_CONVERSIONS = 4'h8;
  localparam logic [3:0] ZERO_NIBBLE     = 4'h0;

  // Special source codes.
  localparam logic [3:0] SPECIAL_SOURCE_CODE = 4'h1;
  localparam logic [3:0] HIGH_REF_CODE       = 4'h4;
  localparam logic [3:0] LOW_REF_CODE        = 4'h5;
  localparam logic [3:0] MID_REF_CODE        = 4'h6;

  typedef enum logic [1:0] {IDLE, SAMPLING, CONVERTING} sequencer_state_type;

  function automatic logic [3:0] decode_length(input logic [3:0] field);
    if (field == ZERO_NIBBLE || field[3]) begin
      decode_length = MAX_CONVERSIONS;
    end else begin
      decode_length = field;
    end
  endfunction : decode_length

  function automatic logic [2:0] analog_of_code(input logic [3:0] code);
    if (code[3]) begin
      analog_of_code = LAST_ANALOG;
    end else begin
      analog_of_code = code[2:0];
    end
  endfunction : analog_of_code

  function automatic logic special_code_valid(input logic [3:0] code);
    special_code_valid = (code == SPECIAL_SOURCE_CODE) || (code == HIGH_REF_CODE) ||
                         (code == LOW_REF_CODE) || (code == MID_REF_CODE);
  endfunction : special_code_valid

endpackage : adc_start_pkg

// ==== hdl/converter_tick_divider.sv ====
// Divider that makes the one-cycle converter clock enable from the bus clock.
`timescale 1ns/1ps
module converter_tick_divider
  import adc_start_pkg::*;
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // Control
  input  wire logic restart_i,
  // Enable pulse
  output logic      tick_o
);

  logic [DIVIDER_WIDTH-1:0] count;

  // Restarting keeps each sampling phase a whole number of converter cycles long.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || restart_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else if (count == DIVIDER_WIDTH'(CONVERTER_DIVIDE - 1)) begin
      count  <= '0;
      tick_o <= 1'b1;
    end else begin
      count  <= count + DIVIDER_WIDTH'(1);
      tick_o <= 1'b0;
    end
  end

endmodule : converter_tick_divider

// ==== hdl/trigger_input_sync.sv ====
// Three-stage synchroniser and rising-edge detector for the external trigger pin.
`timescale 1ns/1ps
module trigger_input_sync (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // Pin
  input  wire logic pin_i,
  // Event
  output logic      rise_o
);

  logic [2:0] stage;
  logic       level;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], pin_i};
    end
  end

  // The first stage may be metastable, so only the later two decide a change.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      level  <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      rise_o <= (stage[1] == stage[2]) && stage[2] && !level;
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end

endmodule : trigger_input_sync
